// *** hw/ssq_sequencer.sv ***
// Purpose: phase sequencer and serial result port of a SAR converter
// Assumes: host drives conversion_start and serial clock as pins
// Notes: data changes after host clock falls, host samples on rise;
//   there is no done pin, so the host must hold start long enough;
//   a start edge during readout cuts the word short on purpose;
//   host pins pass three flops, so pulses under two cycles are lost
//
// Contract
// - calibrate after power-up, then acquire unaided
// - only two phases: acquisition and conversion; the code also has a calibration phase after reset, with its own output
// - track input until conversion_start rises
// - start rise opens switches, begins conversion
// - started conversion always runs to completion
// - conversion_time fixed internally, host cannot change
// - result driven after done and start low
// - result shifted MSB first, one per clock
// - acquisition already running during result shift
// - result word is 16, 14 or 12 bits

`include "ssq_consts.svh"

module ssq_sequencer
    import ssq_pkg::*;
#(
    parameter int RES_BITS = `SSQ_RES_BITS,
    parameter int CAL_CYCLES = `SSQ_CAL_CYCLES,
    parameter int CONV_CYCLES = `SSQ_CONV_CYCLES
) (
    // clock and power-up reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // host pins
    input wire logic i_conversion_start,
    input wire logic i_sclk,
    output logic o_sdo,
    output logic o_sdo_oe,
    // analog core
    input wire logic [RES_BITS-1:0] i_conv_result,
    output logic o_track,
    output logic o_converting,
    output logic o_calibrating
);

    // bit counter must hold the full word length, not one less
    localparam int CNT_W = $clog2(RES_BITS + 1);
    localparam logic [`SSQ_TIMER_W-1:0] CAL_LAST =
        `SSQ_TIMER_W'(CAL_CYCLES - 1);
    localparam logic [`SSQ_TIMER_W-1:0] CONV_LAST =
        `SSQ_TIMER_W'(CONV_CYCLES - 1);
    localparam logic [CNT_W-1:0] BITS_ALL = CNT_W'(RES_BITS);
    localparam logic [CNT_W-1:0] BITS_ONE = CNT_W'(1);

    ssq_state_t state;
    ssq_state_t next_state;
    logic [`SSQ_TIMER_W-1:0] timer;
    logic [RES_BITS-1:0] result;
    logic [RES_BITS-1:0] shreg;
    logic [CNT_W-1:0] bits_left;
    logic start_lvl;
    logic start_prev;
    logic sclk_lvl;
    logic sclk_prev;
    logic start_rise;
    logic sclk_fall;
    logic timer_end;

    // both host pins come from outside the core clock domain
    // a filtered level is passed on; the edge finders sit below
    ssq_sync3 u_sync_start (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_pin(i_conversion_start),
        .o_level(start_lvl)
    );

    ssq_sync3 u_sync_sclk (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_pin(i_sclk),
        .o_level(sclk_lvl)
    );

    // edge finders on the filtered levels
    // previous levels reset low to match the idle pins, so no
    // false edge follows reset
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            start_prev <= 1'b0;
            sclk_prev <= 1'b0;
        end else begin
            start_prev <= start_lvl;
            sclk_prev <= sclk_lvl;
        end
    end

    assign start_rise = start_lvl & ~start_prev;
    assign sclk_fall = ~sclk_lvl & sclk_prev;

    // phase timer end, length chosen by the current phase only
    always_comb begin
        // acquisition and done are untimed: they end on host action
        timer_end = 1'b0;
        if (state == SSQ_CAL) begin
            timer_end = (timer == CAL_LAST);
        end else if (state == SSQ_CONV) begin
            timer_end = (timer == CONV_LAST);
        end
    end

    // phase sequence; done is still the conversion phase seen from outside
    always_comb begin
        next_state = state;
        unique case (state)
            SSQ_CAL: begin
                // start edges are ignored until calibration ends
                if (timer_end) begin
                    next_state = SSQ_ACQ;
                end
            end
            SSQ_ACQ: begin
                // tracking lasts as long as the host waits
                if (start_rise) begin
                    next_state = SSQ_CONV;
                end
            end
            SSQ_CONV: begin
                // no host input is looked at here, so nothing aborts it
                if (timer_end) begin
                    next_state = SSQ_DONE;
                end
            end
            SSQ_DONE: begin
                // result waits for the host to lower the start pin
                // with no done pin the host may hold start for long
                if (!start_lvl) begin
                    next_state = SSQ_ACQ;
                end
            end
        endcase
    end

    // state and phase timer
    // the timer restarts on every phase change
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= SSQ_CAL;
            timer <= '0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                timer <= '0;
            end else if (state == SSQ_CAL || state == SSQ_CONV) begin
                // untimed phases hold the count: a long acquisition
                // would only wrap it and toggle flops for nothing
                timer <= timer + 1'b1;
            end
        end
    end

    // capture the core result as the conversion completes
    // the core must hold its result steady on that last cycle
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            result <= '0;
        end else if (state == SSQ_CONV && timer_end) begin
            result <= i_conv_result;
        end
    end

    // serial port: first bit on start low, next bit on each clock fall
    // the host samples on its rising clock, so each bit changes only
    // after a fall and stands for a whole host clock period; too few
    // host clocks leave the line driven until the next start edge
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            shreg <= '0;
            bits_left <= '0;
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else if (state == SSQ_DONE && !start_lvl) begin
            shreg <= result;
            bits_left <= BITS_ALL;
            o_sdo <= result[RES_BITS-1];
            o_sdo_oe <= 1'b1;
        end else if (start_rise) begin
            // a new start cuts a late readout to keep the sample clean
            bits_left <= '0;
            o_sdo_oe <= 1'b0;
            o_sdo <= 1'b0;
        end else if (o_sdo_oe && sclk_fall) begin
            if (bits_left > BITS_ONE) begin
                shreg <= {shreg[RES_BITS-2:0], 1'b0};
                o_sdo <= shreg[RES_BITS-2];
                bits_left <= bits_left - 1'b1;
            end else begin
                // release after the last bit has been taken
                bits_left <= '0;
                o_sdo_oe <= 1'b0;
                o_sdo <= 1'b0;
            end
        end
    end

    // phase outputs to the analog core, registered from the next state
    // taken from next_state so they move on the same edge as the phase
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_track <= 1'b0;
            o_converting <= 1'b0;
            o_calibrating <= 1'b1;
        end else begin
            o_track <= (next_state == SSQ_ACQ);
            o_converting <= (next_state == SSQ_CONV) ||
                (next_state == SSQ_DONE);
            o_calibrating <= (next_state == SSQ_CAL);
        end
    end

endmodule

// *** hw/ssq_consts.svh ***
// Purpose: shared numbers of the conversion sequencer
// Assumes: core clock of 200 MHz
// Notes: times in ns, conversion cycle count derived from them
`ifndef SSQ_CONSTS_SVH
`define SSQ_CONSTS_SVH

// core clock period in ns
`define SSQ_MCLK_PERIOD_NS 5
// fixed conversion time in ns, worst case of the fast grade
`define SSQ_CONV_TIME_NS 710
// conversion cycles, rounded up so the result is always settled
`define SSQ_CONV_CYCLES \
    ((`SSQ_CONV_TIME_NS + `SSQ_MCLK_PERIOD_NS - 1) / `SSQ_MCLK_PERIOD_NS)
// power-up calibration length in core cycles
`define SSQ_CAL_CYCLES 8192
// result width of the widest variant
`define SSQ_RES_BITS 16
// width of the shared phase timer
`define SSQ_TIMER_W 20
// host quiet gap before a new start, in ns
`define SSQ_QUIET_GAP_NS 10

`endif

// *** hw/ssq_pkg.sv ***
// Purpose: types of the conversion sequencer
// Assumes: nothing beyond the consts header
// Notes: phase encoding is left to the tools
package ssq_pkg;

    // operating phase of the converter
    typedef enum logic [2:0] {
        SSQ_CAL,
        SSQ_ACQ,
        SSQ_CONV,
        SSQ_DONE
    } ssq_state_t;

endpackage

// *** hw/ssq_sync3.sv ***
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to i_mclk
// Notes: output moves only when stages two and three agree
module ssq_sync3 (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // pin side
    input wire logic i_pin,
    // core side
    output logic o_level
);

    logic s1;
    logic s2;
    logic s3;

    // stage one feeds stage two only, to keep metastability contained
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change counts once the later stages agree
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_level <= 1'b0;
        end else if (s2 == s3) begin
            o_level <= s3;
        end
    end

endmodule

// *** bench/ssq_host.sv ***
// Purpose: host model, drives start and serial clock, reads sdo
// Assumes: sclk period 160 ns, idle low outside frames
// Notes: no done pin, so start is held by a guessed margin
module ssq_host (
    // host pins
    output logic o_start,
    output logic o_sclk,
    input wire logic i_sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    // clock stands still outside frames and during conversion
    initial begin
        o_start = 1'b0;
        o_sclk = 1'b0;
    end
    // host picks the acquisition length by its start timing
    task automatic sample(input int hold_ns, input int nbits,
        output logic [15:0] word);
        word = 16'h0000;
        o_start <= 1'b1;
        #(hold_ns);
        o_start <= 1'b0;
        #100;
        // a word, or its cut head, clocked out
        repeat (nbits) begin
            #80 o_sclk <= 1'b1;
            word = {word[14:0], i_sdo};
            #80 o_sclk <= 1'b0;
        end
        #40; // quiet gap before the next start
    endtask
endmodule

// *** bench/ssq_sequencer_checker.sv ***
// Purpose: port checker of the sequencer
// Assumes: pins seen about five core cycles late
// Notes: bounds allow for that delay
module ssq_sequencer_checker #(
    parameter int RES_BITS = 16,
    parameter int CAL_CYCLES = 16,
    parameter int CONV_CYCLES = 8
) (
    // watched ports
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_conversion_start,
    input wire logic i_sclk,
    input wire logic o_sdo,
    input wire logic o_sdo_oe,
    input wire logic [RES_BITS-1:0] i_conv_result,
    input wire logic o_track,
    input wire logic o_converting,
    input wire logic o_calibrating
);
    int run;
    // cycles spent busy, calibrating or converting
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            run <= 0;
        end else begin
            run <= (o_calibrating || o_converting) ? run + 1 : 0;
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    property p_two; !(o_track && o_converting); endproperty
    a_two: assert property (p_two) else $error("overlap");
    property p_cal; $fell(o_calibrating) |-> run >= CAL_CYCLES - 2; endproperty
    a_cal: assert property (p_cal) else $error("cal short");
    property p_go; $rose(o_converting) |-> $fell(o_track); endproperty
    a_go: assert property (p_go) else $error("no freeze");
    property p_trk;
        $fell(o_track) |-> $past(i_conversion_start, 5);
    endproperty
    a_trk: assert property (p_trk) else $error("early end");
    property p_len; $fell(o_converting) |-> run >= CONV_CYCLES; endproperty
    a_len: assert property (p_len) else $error("conv cut");
    property p_max;
        o_converting && run > CONV_CYCLES + 8 |-> $past(i_conversion_start, 8);
    endproperty
    a_max: assert property (p_max) else $error("conv long");
    property p_oe;
        $rose(o_sdo_oe) |-> $past(o_converting) && !i_conversion_start;
    endproperty
    a_oe: assert property (p_oe) else $error("early sdo");
    property p_acq; o_sdo_oe |-> o_track; endproperty
    a_acq: assert property (p_acq) else $error("not tracking");
    property p_sh; o_sdo_oe && $past(o_sdo_oe) && $changed(o_sdo) |-> !i_sclk;
    endproperty
    a_sh: assert property (p_sh) else $error("bad shift");
    // main scenarios
    c_cal: cover property ($fell(o_calibrating));
    c_conv: cover property ($fell(o_converting));
    c_read: cover property ($fell(o_sdo_oe));
    c_cut: cover property ($fell(o_sdo_oe) && $rose(o_converting));
endmodule
bind ssq_sequencer ssq_sequencer_checker #(.RES_BITS(RES_BITS),
    .CAL_CYCLES(CAL_CYCLES), .CONV_CYCLES(CONV_CYCLES)) checker_i (
    .i_mclk, .i_resetn, .i_conversion_start, .i_sclk, .o_sdo, .o_sdo_oe,
    .i_conv_result, .o_track, .o_converting, .o_calibrating);

// *** bench/ssq_sequencer_tb_top.sv ***
// Purpose: self-checking bench of the conversion sequencer
// Assumes: short calibration and conversion counts
// Notes: model queue holds each result until it is read
module ssq_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CAL = 16;
    localparam int CONV = 8;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_conversion_start, i_sclk, o_sdo, o_sdo_oe;
    logic o_track, o_converting, o_calibrating;
    logic [15:0] i_conv_result = 16'h0000;
    logic [15:0] word, r, want;
    int nb;
    logic sdo_line;
    logic [15:0] exp_q[$];
    int failures = 0;
    int total_checks = 0;
    always #2.5 i_mclk = ~i_mclk;
    // a released line reads high, so a read outside the frame shows
    assign sdo_line = o_sdo_oe ? o_sdo : 1'b1;
    // full 16 bit variant
    ssq_sequencer #(.RES_BITS(16), .CAL_CYCLES(CAL), .CONV_CYCLES(CONV))
    ssq_sequencer_i (.i_mclk, .i_resetn, .i_conversion_start, .i_sclk,
        .o_sdo, .o_sdo_oe, .i_conv_result, .o_track, .o_converting,
        .o_calibrating);
    ssq_host ssq_host_i (.o_start(i_conversion_start), .o_sclk(i_sclk),
        .i_sdo(sdo_line));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // forty frames take about 110 us
    initial begin
        #400000;
        failures++;
        stop_test();
    end
    // reset, calibration, then frames with random start timing
    initial begin
        void'($urandom(32'he2bc_55a7));
        repeat (20) @(posedge i_mclk);
        check({o_calibrating, o_track, o_sdo_oe}, 16'h0004);
        i_resetn <= 1'b1;
        repeat (CAL + 10) @(posedge i_mclk);
        check({o_calibrating, o_track, o_sdo_oe}, 16'h0002);
        for (int n = 0; n < 40; n++) begin
            @(posedge i_mclk);
            r = (n == 0) ? 16'h8000 : (n == 1) ? 16'h0001 : 16'($urandom);
            i_conv_result <= r;
            exp_q.push_back(r);
            // some frames read only half a word; the next start cuts it
            nb = (n % 10 == 5) ? 8 : 16;
            // short holds drop start while converting
            ssq_host_i.sample(30 + $urandom_range(270), nb, word);
            check(word, exp_q.pop_front() >> (16 - nb));
            // a cut word leaves the line driven until the next start
            want = (nb == 16) ? 16'h0002 : 16'h0003;
            check({o_converting, o_track, o_sdo_oe}, want);
        end
        stop_test();
    end
endmodule
